// ==== src/hd_mode_pkg.sv ====
// package: register map, setting codes and mode carriers for the hd mode register bank
package hd_mode_pkg;
   // --------------------------------------------------------------
   // register offsets (subaddress, byte address = 4 * index)
   // --------------------------------------------------------------
   localparam logic [7:0] IDX_POWER_PLL = 8'h00;
   localparam logic [7:0] IDX_INPUT_MODE = 8'h01;
   localparam logic [7:0] IDX_OUTPUT_FMT = 8'h02;
   localparam logic [7:0] IDX_SOFT_RESET = 8'h17;
   localparam logic [7:0] IDX_HD_STD = 8'h30;
   localparam logic [7:0] IDX_HD_VALID = 8'h31;
   localparam logic [7:0] IDX_HD_WIDTH = 8'h33;
   localparam int ADDR_SHIFT = 2;
   // --------------------------------------------------------------
   // reset values and decoded setting codes
   // --------------------------------------------------------------
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   localparam logic [7:0] CODE_SOFT_RESET = 8'h02;
   localparam logic [7:0] CODE_DACS_PLL_4X = 8'h1c;
   localparam logic [7:0] CODE_SINGLE_RATE = 8'h10;
   localparam logic [7:0] CODE_DOUBLE_RATE = 8'h20;
   localparam logic [7:0] CODE_RGB_SYNC = 8'h10;
   localparam logic [7:0] CODE_1080I_EMB = 8'h6c;
   localparam logic [7:0] CODE_1080I_SEP = 8'h18;
   localparam logic [7:0] CODE_720P_EMB = 8'h2c;
   localparam logic [7:0] CODE_PIX_VALID = 8'h01;
   localparam logic [7:0] CODE_TEN_BIT = 8'h6c;
   // soft reset pulse length in system clocks
   localparam int SOFT_RESET_CYCLES = 2;
   // --------------------------------------------------------------
   // decoded mode carrier
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      STD_NONE = 2'h0,
      STD_1080I = 2'h1,
      STD_720P = 2'h2
   } hd_std_e;
   typedef struct packed {
      logic dacs_on;
      logic pll_4x;
      logic single_rate;
      logic double_rate;
      logic luma_fall_edge;
      logic rgb_out;
      logic rgb_sync;
      hd_std_e standard;
      logic embedded_sync;
      logic separate_sync;
      logic eia_770_3;
      logic pixel_valid;
      logic oversample_4x;
      logic ten_bit;
   } hd_mode_s;
endpackage : hd_mode_pkg

// ==== src/hd_mode_config_registers.sv ====
// module: ahb-lite register bank that sets the hd operating mode of the encoder
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
module hd_mode_config_registers
   import hd_mode_pkg::*;
#(
   parameter int SOFT_RESET_LEN = SOFT_RESET_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // decoded mode toward the datapath
   output hd_mode_s mode_o,
   output logic soft_reset_o
);

   // ---------------------------------------------------------------
   // bus address phase capture
   // ---------------------------------------------------------------
   logic wr_pend_q, wr_pend_d;
   logic [7:0] wr_idx_q, wr_idx_d;
   logic [31:0] hrdata_q, hrdata_d;
   wire logic addr_phase = hsel_i & hready_i & htrans_i[1];
   wire logic [7:0] a_idx = haddr_i[9:2];
   wire logic a_high_zero = (haddr_i[31:10] == 22'h0) & (haddr_i[1:0] == 2'h0);

   // registers
   logic [7:0] pwr_q, inmode_q, outfmt_q, srst_q, std_q, valid_q, width_q;
   logic srst_act_q, hready_q, hresp_q;
   logic [$clog2(SOFT_RESET_LEN+1)-1:0] srst_cnt_q, srst_cnt_d;
   hd_mode_s mode_q, mode_d;

   // write strobes per register, taken in the data phase
   function automatic logic wr_hit(input logic pend, input logic [7:0] idx,
                                   input logic [7:0] target);
      wr_hit = pend & (idx == target);
   endfunction : wr_hit

   wire logic wr_pwr = wr_hit(wr_pend_q, wr_idx_q, IDX_POWER_PLL);
   wire logic wr_inmode = wr_hit(wr_pend_q, wr_idx_q, IDX_INPUT_MODE);
   wire logic wr_outfmt = wr_hit(wr_pend_q, wr_idx_q, IDX_OUTPUT_FMT);
   wire logic wr_srst = wr_hit(wr_pend_q, wr_idx_q, IDX_SOFT_RESET);
   wire logic wr_std = wr_hit(wr_pend_q, wr_idx_q, IDX_HD_STD);
   wire logic wr_valid = wr_hit(wr_pend_q, wr_idx_q, IDX_HD_VALID);
   wire logic wr_width = wr_hit(wr_pend_q, wr_idx_q, IDX_HD_WIDTH);
   wire logic [7:0] wbyte = hwdata_i[7:0];

   // ---------------------------------------------------------------
   // read mux: unmapped addresses read zero
   // ---------------------------------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (a_high_zero) begin
         case (a_idx)
            IDX_POWER_PLL: rd_byte = pwr_q;
            IDX_INPUT_MODE: rd_byte = inmode_q;
            IDX_OUTPUT_FMT: rd_byte = outfmt_q;
            IDX_SOFT_RESET: rd_byte = srst_q;
            IDX_HD_STD: rd_byte = std_q;
            IDX_HD_VALID: rd_byte = valid_q;
            IDX_HD_WIDTH: rd_byte = width_q;
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // read data is captured at the address phase so it stands in the data phase
   assign hrdata_d = (addr_phase & ~hwrite_i) ? {24'h0, rd_byte} : hrdata_q;
   assign wr_pend_d = addr_phase & hwrite_i & a_high_zero;
   assign wr_idx_d = a_idx;

   // ---------------------------------------------------------------
   // soft reset pulse: counts down after a 0x02 write to 0x17
   // ---------------------------------------------------------------
   always_comb begin
      srst_cnt_d = srst_cnt_q;
      if (wr_srst && wbyte == CODE_SOFT_RESET) begin
         srst_cnt_d = SOFT_RESET_LEN[$bits(srst_cnt_d)-1:0];
      end else if (srst_cnt_q != '0) begin
         srst_cnt_d = srst_cnt_q - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // mode decode from the register contents
   // ---------------------------------------------------------------
   wire logic dacs_pll = (pwr_q == CODE_DACS_PLL_4X);
   wire logic sdr_sel = (inmode_q == CODE_SINGLE_RATE);
   wire logic ddr_sel = (inmode_q == CODE_DOUBLE_RATE);
   wire logic rgb_sel = (outfmt_q == CODE_RGB_SYNC);
   wire logic s1080_emb = (std_q == CODE_1080I_EMB);
   wire logic s1080_sep = (std_q == CODE_1080I_SEP);
   wire logic s720_emb = (std_q == CODE_720P_EMB);
   wire logic pix_ok = (valid_q == CODE_PIX_VALID);
   // ten-bit input only applies in double rate mode
   wire logic ten_sel = (width_q == CODE_TEN_BIT) & ddr_sel;

   always_comb begin
      mode_d = '0;
      mode_d.dacs_on = dacs_pll;
      mode_d.pll_4x = dacs_pll;
      mode_d.single_rate = sdr_sel;
      mode_d.double_rate = ddr_sel;
      mode_d.luma_fall_edge = ddr_sel;
      mode_d.rgb_out = rgb_sel;
      mode_d.rgb_sync = rgb_sel;
      if (s1080_emb || s1080_sep) begin
         mode_d.standard = STD_1080I;
      end else if (s720_emb) begin
         mode_d.standard = STD_720P;
      end else begin
         mode_d.standard = STD_NONE;
      end
      mode_d.embedded_sync = s1080_emb | s720_emb;
      mode_d.separate_sync = s1080_sep;
      mode_d.eia_770_3 = s1080_emb | s1080_sep | s720_emb;
      mode_d.pixel_valid = pix_ok;
      mode_d.oversample_4x = pix_ok & dacs_pll;
      mode_d.ten_bit = ten_sel;
      // a soft reset holds the datapath quiet while it runs
      if (srst_cnt_q != '0) begin
         mode_d.pixel_valid = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // bus state
   // ---------------------------------------------------------------
   // a write is seen in its address phase and carried out in its data phase:
   // the place is kept here for one clock, the byte comes with hwdata then.
   // back to back writes work because each stage holds a single transfer.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_idx_q <= wr_idx_d;
      end
   end

   // read data holds until the next read, so it stands through the data phase
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         hrdata_q <= 32'h0;
      end else begin
         hrdata_q <= hrdata_d;
      end
   end

   // bus answer flops: zero wait states and an okay answer in every cycle
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         hready_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         hready_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // power and pll control register
   // ---------------------------------------------------------------
   // only the low byte lane is kept; upper lanes are dropped on purpose
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pwr_q <= REG_RESET_VAL;
      end else if (wr_pwr) begin
         pwr_q <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // input mode select register
   // ---------------------------------------------------------------
   // single and double rate codes share this byte, so one wins at a time
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         inmode_q <= REG_RESET_VAL;
      end else if (wr_inmode) begin
         inmode_q <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // output format control register
   // ---------------------------------------------------------------
   // any code other than the rgb one leaves component output selected
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         outfmt_q <= REG_RESET_VAL;
      end else if (wr_outfmt) begin
         outfmt_q <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // soft reset control register
   // ---------------------------------------------------------------
   // keeps its value so software can read it back; the pulse is separate
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         srst_q <= REG_RESET_VAL;
      end else if (wr_srst) begin
         srst_q <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // hd standard select register
   // ---------------------------------------------------------------
   // one byte picks both the line standard and where timing comes from
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         std_q <= REG_RESET_VAL;
      end else if (wr_std) begin
         std_q <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // pixel valid and oversampling register
   // ---------------------------------------------------------------
   // the datapath ignores pixels until this byte holds the valid code
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         valid_q <= REG_RESET_VAL;
      end else if (wr_valid) begin
         valid_q <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // input width control register
   // ---------------------------------------------------------------
   // stored even in single rate mode; the decode only honours it in double rate
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         width_q <= REG_RESET_VAL;
      end else if (wr_width) begin
         width_q <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // soft reset pulse
   // ---------------------------------------------------------------
   // the counter runs down after the reset code is written
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         srst_cnt_q <= '0;
      end else begin
         srst_cnt_q <= srst_cnt_d;
      end
   end

   // a flop of its own keeps the pulse glitch free toward the datapath
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         srst_act_q <= 1'b0;
      end else begin
         srst_act_q <= (srst_cnt_d != '0);
      end
   end

   // ---------------------------------------------------------------
   // decoded mode
   // ---------------------------------------------------------------
   // mode lags the register write by one clock
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mode_q <= '0;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign hrdata_o = hrdata_q;
   assign hreadyout_o = hready_q; // zero wait states, never stalls
   assign hresp_o = hresp_q;
   assign mode_o = mode_q;
   assign soft_reset_o = srst_act_q;

endmodule : hd_mode_config_registers

// ==== testbench/hd_mode_chk.sv ====
// checker: bus write to decoded mode timing of the hd mode register bank
`timescale 1ns/10ps
module hd_mode_chk
   import hd_mode_pkg::*;
#(
   parameter int SOFT_RESET_LEN = 2
) (
   // bus side
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   // mode side
   input wire hd_mode_s mode_o,
   input wire logic soft_reset_o
);
   logic wr_q;
   logic [7:0] idx_q;
   // place and byte of a write in its data phase, all ones when no write is there
   wire logic [15:0] wk = wr_q ? {idx_q, hwdata_i[7:0]} : 16'hffff;
   // remember the address phase so the data phase can be matched to it
   always_ff @(posedge clk_sys_i) begin
      wr_q <= rst_n_i && hsel_i && hready_i && htrans_i[1] && hwrite_i;
      idx_q <= haddr_i[9:2];
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_srst; wk == 16'h1702 |-> ##1 soft_reset_o [*2] ##1 !soft_reset_o; endproperty
   a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
   property p_pwr; wk == 16'h001c |-> ##2 mode_o.dacs_on && mode_o.pll_4x; endproperty
   a_pwr: assert property (p_pwr) else $error("dac and pll not on");
   property p_sdr; wk == 16'h0110 |-> ##2 mode_o.single_rate && !mode_o.double_rate; endproperty
   a_sdr: assert property (p_sdr) else $error("single rate not set");
   property p_ddr; wk == 16'h0120 |-> ##2 mode_o.double_rate && mode_o.luma_fall_edge; endproperty
   a_ddr: assert property (p_ddr) else $error("double rate not set");
   property p_rgb; wk == 16'h0210 |-> ##2 mode_o.rgb_out && mode_o.rgb_sync; endproperty
   a_rgb: assert property (p_rgb) else $error("rgb output not set");
   property p_emb;
      wk == 16'h306c |-> ##2 mode_o.standard == STD_1080I && mode_o.embedded_sync;
   endproperty
   a_emb: assert property (p_emb) else $error("1080i embedded not set");
   property p_sep;
      wk == 16'h3018 |-> ##2 mode_o.standard == STD_1080I && mode_o.separate_sync;
   endproperty
   a_sep: assert property (p_sep) else $error("1080i separate not set");
   property p_720; wk == 16'h302c |-> ##2 mode_o.standard == STD_720P && mode_o.eia_770_3; endproperty
   a_720: assert property (p_720) else $error("720p not set");
   property p_valid;
      wk == 16'h3101 |-> ##2 mode_o.pixel_valid && mode_o.oversample_4x == mode_o.dacs_on;
   endproperty
   a_valid: assert property (p_valid) else $error("pixel valid not set");
   property p_ten; wk == 16'h336c |-> ##2 mode_o.ten_bit == mode_o.double_rate; endproperty
   a_ten: assert property (p_ten) else $error("ten bit input wrong");
endmodule : hd_mode_chk

bind hd_mode_config_registers hd_mode_chk #(.SOFT_RESET_LEN(SOFT_RESET_LEN)) u_chk (.clk_sys_i,
   .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .mode_o, .soft_reset_o);

// ==== testbench/hd_host_model.sv ====
// host model: ahb-lite master issuing single whole-word transfers
`timescale 1ns/10ps
module hd_host_model (
   // clock and slave answer
   input wire logic clk_sys_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   // master outputs
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [31:0] hwdata_o
);
   // idle bus at time zero
   initial begin
      haddr_o = '0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hwdata_o = '0;
   end
   // address phase, then data phase, each held until hready is seen high
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] rd);
      @(posedge clk_sys_i);
      haddr_o <= {22'h0, idx, 2'h0};
      htrans_o <= 2'h2;
      hwrite_o <= w;
      do @(posedge clk_sys_i); while (hready_i !== 1'b1);
      htrans_o <= 2'h0;
      hwdata_o <= d;
      do @(posedge clk_sys_i); while (hready_i !== 1'b1);
      rd = hrdata_i;
      hwdata_o <= ~d; // released data must not look like the last value
   endtask : xfer
endmodule : hd_host_model

// ==== testbench/tb_hd_mode_config_registers.sv ====
// testbench: programs the hd mode register bank through the host model and checks it
`timescale 1ns/10ps
module tb_hd_mode_config_registers;
   import hd_mode_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic hready, hresp, hwrite, srst;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   hd_mode_s mode;
   logic [7:0] mdl [logic [7:0]];
   logic [7:0] regs [7] = '{8'h00, 8'h01, 8'h02, 8'h17, 8'h30, 8'h31, 8'h33};
   logic [7:0] stds [3] = '{8'h6c, 8'h18, 8'h2c};
   int error_cnt = 0;
   int checks_done = 0;
   int n;
   // select and size tied: one slave, word transfers only
   hd_mode_config_registers DUT (.clk_sys_i, .rst_n_i, .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .mode_o(mode), .soft_reset_o(srst));
   hd_host_model host (.clk_sys_i, .hready_i(hready), .hrdata_i(hrdata), .haddr_o(haddr),
      .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
   initial begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // write and keep the model in step; unmapped places keep nothing
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      host.xfer(1'b1, idx, d, rd);
      if (mdl.exists(idx)) mdl[idx] = d[7:0];
   endtask : wr
   task automatic rdc(input logic [7:0] idx);
      host.xfer(1'b0, idx, 32'h0, rd);
      chk("rdata", rd, mdl.exists(idx) ? {24'h0, mdl[idx]} : 32'h0);
      chk("hresp", hresp, 1'b0);
   endtask : rdc
   // expected decoded mode from model bytes; odd codes leave fields off
   function automatic hd_mode_s exp_mode();
      logic d, dr, em, se;
      hd_std_e st;
      d = mdl[8'h00] == 8'h1c;
      dr = mdl[8'h01] == 8'h20;
      em = mdl[8'h30] inside {8'h6c, 8'h2c};
      se = mdl[8'h30] == 8'h18;
      st = mdl[8'h30] == 8'h2c ? STD_720P : (em || se) ? STD_1080I : STD_NONE;
      return {d, d, mdl[8'h01] == 8'h10, dr, dr, {2{mdl[8'h02] == 8'h10}}, st, em, se,
              st != STD_NONE, mdl[8'h31] == 8'h01, mdl[8'h31] == 8'h01 && d,
              mdl[8'h33] == 8'h6c && dr};
   endfunction : exp_mode
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      error_cnt++;
      print_verdict;
   end
   initial begin
      void'($urandom(51315));
      foreach (regs[i]) mdl[regs[i]] = REG_RESET_VAL;
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      foreach (regs[i]) rdc(regs[i]);
      chk("mode", 32'(mode), 32'(exp_mode()));
      // random bytes with random upper lanes, one unmapped place among them
      for (int i = 0; i < 8; i++) wr(i < 7 ? regs[i] : 8'h05, $urandom);
      foreach (regs[i]) rdc(regs[i]);
      rdc(8'h05);
      chk("mode", 32'(mode), 32'(exp_mode()));
      $display("test reset and readback done");
      // each hd script: single or double rate, rgb or not, three standards
      for (int k = 0; k < 12; k++) begin
         wr(8'h17, 32'h02);
         n = 0;
         for (int j = 0; j < 5; j++) begin
            #1 n += srst;
            if (j == 1 && k > 0) chk("valid in reset", mode.pixel_valid, 1'b0);
            @(posedge clk_sys_i);
         end
         chk("soft reset cycles", n, SOFT_RESET_CYCLES);
         wr(8'h00, 32'h1c);
         wr(8'h01, k[0] ? 32'h20 : 32'h10);
         wr(8'h02, k[1] ? 32'h10 : 32'h00);
         wr(8'h30, {24'h0, stds[k / 4]});
         wr(8'h31, 32'h01);
         wr(8'h33, 32'h6c);
         repeat (3) @(posedge clk_sys_i);
         #1 chk("mode", 32'(mode), 32'(exp_mode()));
      end
      $display("test hd scripts done");
      print_verdict;
   end
endmodule : tb_hd_mode_config_registers
